// File: core/gdc_pkg.sv
// Shared constants for the gate driver serial control link
package gdc_pkg;
    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int CMD_BITS = 5;
    localparam int DATA_W = 11;
    localparam int ADDR_W = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
    localparam logic [CNT_W-1:0] CNT_OVER = 5'h11;
    // Clock and link timing
    localparam int CLK_NS = 10;
    localparam int T_RST_NS = 8000;
    localparam int RST_CYC = T_RST_NS / CLK_NS;
    localparam int T_SLEEP_NS = 20000;
    localparam int SLEEP_CYC = T_SLEEP_NS / CLK_NS;
    localparam int T_WAKE_NS = 10000;
    localparam int WAKE_CYC = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_CSGAP_NS = 400;
    localparam int GAP_CYC = (T_CSGAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_PULSE_NS = 4000;
    localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_SCLK_HALF_NS = 40;
    localparam int HALF_CYC = T_SCLK_HALF_NS / CLK_NS;
    // Device register map
    localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_CFG_LO = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_CFG_HI = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_OCP = 4'h5;
    localparam int CLR_BIT = 0;
    localparam int OCP_LSB = 6;
    localparam logic [1:0] OCP_REPORT = 2'h2;
    localparam logic [DATA_W-1:0] REG_DEFAULT = 11'h000;
    // Sync reset value, order: enable, cs_n, sclk, sdi, supply
    localparam logic [4:0] SYNC_RST = 5'h08;
    // Host register map (byte addresses)
    localparam logic [7:0] H_CTRL = 8'h00;
    localparam logic [7:0] H_TX = 8'h04;
    localparam logic [7:0] H_RX = 8'h08;
    localparam logic [7:0] H_STAT = 8'h0C;
    localparam int HC_EN = 0;
    localparam int HC_GO = 1;
    localparam int HC_PULSE = 2;
    localparam int HS_BUSY = 0;
    localparam int HS_READY = 1;
endpackage

// File: core/gdc_spi_if.sv
// Pin bundle between the serial master and the gate driver
`timescale 1ns/1ps
interface gdc_spi_if;
    logic enable;
    logic chip_select_n;
    logic sclk;
    logic sdi;
    logic sdo_o;
    logic sdo_oe;
    logic sdo;
    // Released line reads low, as with a weak pull-down
    assign sdo = sdo_oe & sdo_o;
    modport dev (
        input enable,
        input chip_select_n,
        input sclk,
        input sdi,
        output sdo_o,
        output sdo_oe
    );
    modport host (
        output enable,
        output chip_select_n,
        output sclk,
        output sdi,
        input sdo
    );
endinterface

// File: core/gdc_host.sv
// Serial master with AHB-Lite register front end
`timescale 1ns/1ps
module gdc_host #(
    parameter int HALF = gdc_pkg::HALF_CYC,
    parameter int WAKE = gdc_pkg::WAKE_CYC,
    parameter int GAP = gdc_pkg::GAP_CYC,
    parameter int PULSE = gdc_pkg::PULSE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    gdc_spi_if.host spi
);
    if (HALF < 4 || WAKE < 1 || GAP < 1 || PULSE < 1)
    begin : g_chk
        $error("gdc_host: timing parameter out of range");
    end

    typedef enum logic [5:0] {
        H_IDLE = 6'b000001,
        H_LEAD = 6'b000010,
        H_HIGH = 6'b000100,
        H_LOW = 6'b001000,
        H_GAP = 6'b010000,
        H_PULSE = 6'b100000
    } gdc_hstate_t;

    gdc_hstate_t st_q;
    logic dph_q, wr_q, en_reg_q, go_q, pulse_q, ready;
    logic [7:0] addr_q;
    logic [15:0] tx_q, sh_q, rx_q, rxw_q;
    logic [1:0] sdo_s_q;
    logic [15:0] cnt_q;
    logic [4:0] bit_q;
    logic [31:0] wake_q;
    logic cs_n_q, sclk_q, sdi_q, en_pin_q;
    logic tick;

    assign hresp = 1'b0;
    assign spi.enable = en_pin_q;
    assign spi.chip_select_n = cs_n_q;
    assign spi.sclk = sclk_q;
    assign spi.sdi = sdi_q;
    assign ready = (wake_q == 32'(WAKE));
    assign tick = (cnt_q == 16'(HALF - 1));

    ////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state so read data comes from a flop
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            dph_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
        end
        else if (hsel && htrans[1] && hready)
        begin
            dph_q <= 1'b1;
            wr_q <= hwrite;
            addr_q <= haddr[7:0];
            hreadyout <= 1'b0;
        end
        else if (dph_q)
        begin
            dph_q <= 1'b0;
            hreadyout <= 1'b1;
            unique case (addr_q)
                gdc_pkg::H_CTRL: hrdata <= {31'h00000000, en_reg_q};
                gdc_pkg::H_TX: hrdata <= {16'h0000, tx_q};
                gdc_pkg::H_RX: hrdata <= {16'h0000, rxw_q};
                gdc_pkg::H_STAT: hrdata <= {30'h00000000, ready,
                    (st_q != H_IDLE) | go_q | pulse_q};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // Register writes; start requests wait here until the engine is free
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            en_reg_q <= 1'b0;
            tx_q <= 16'h0000;
            go_q <= 1'b0;
            pulse_q <= 1'b0;
        end
        else
        begin
            if (dph_q && wr_q && addr_q == gdc_pkg::H_CTRL)
            begin
                en_reg_q <= hwdata[gdc_pkg::HC_EN];
                if (hwdata[gdc_pkg::HC_GO])
                    go_q <= 1'b1;
                if (hwdata[gdc_pkg::HC_PULSE])
                    pulse_q <= 1'b1;
            end
            else
            begin
                if (st_q == H_IDLE && go_q && ready)
                    go_q <= 1'b0;
                else if (st_q == H_IDLE && pulse_q && !go_q)
                    pulse_q <= 1'b0;
            end
            if (dph_q && wr_q && addr_q == gdc_pkg::H_TX)
                tx_q <= hwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Wake timer restarts each time enable goes low
    always_ff @(posedge sys_clk)
    begin
        if (rst || !en_pin_q)
            wake_q <= 32'h00000000;
        else if (!ready)
            wake_q <= wake_q + 32'h00000001;
    end

    // Device output is asynchronous to us
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            sdo_s_q <= 2'h0;
        else
            sdo_s_q <= {sdo_s_q[0], spi.sdo};
    end

    ////////////////////////////////////////////////////////////////////
    // Frame and enable pulse sequencer
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= H_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 5'h00;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            sdi_q <= 1'b0;
            sh_q <= 16'h0000;
            rx_q <= 16'h0000;
            rxw_q <= 16'h0000;
            en_pin_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_q + 16'h0001;
            unique case (st_q)
                H_IDLE:
                begin
                    en_pin_q <= en_reg_q;
                    cnt_q <= 16'h0000;
                    bit_q <= 5'h00;
                    if (go_q && ready)
                    begin
                        cs_n_q <= 1'b0;
                        sh_q <= tx_q;
                        st_q <= H_LEAD;
                    end
                    else if (pulse_q && en_reg_q)
                    begin
                        en_pin_q <= 1'b0;
                        st_q <= H_PULSE;
                    end
                end
                H_LEAD, H_LOW:
                begin
                    if (tick)
                    begin
                        cnt_q <= 16'h0000;
                        if (st_q == H_LOW)
                            rx_q <= {rx_q[14:0], sdo_s_q[1]};
                        if (bit_q == gdc_pkg::CNT_FULL)
                        begin
                            cs_n_q <= 1'b1;
                            rxw_q <= {rx_q[14:0], sdo_s_q[1]};
                            st_q <= H_GAP;
                        end
                        else
                        begin
                            sclk_q <= 1'b1;
                            sdi_q <= sh_q[15];
                            sh_q <= {sh_q[14:0], 1'b0};
                            st_q <= H_HIGH;
                        end
                    end
                end
                H_HIGH:
                begin
                    if (tick)
                    begin
                        cnt_q <= 16'h0000;
                        sclk_q <= 1'b0;
                        bit_q <= bit_q + 5'h01;
                        st_q <= H_LOW;
                    end
                end
                H_GAP:
                begin
                    if (cnt_q == 16'(GAP - 1))
                        st_q <= H_IDLE;
                end
                H_PULSE:
                begin
                    if (cnt_q == 16'(PULSE - 1))
                    begin
                        en_pin_q <= en_reg_q;
                        st_q <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // gdc_host

// File: core/gdc_device.sv
// Gate driver serial port, mode control and fault latch
`timescale 1ns/1ps
// Summary of operation
// - Enable high and supply good means operating
// - Controller waits wake time before talking
// - Serial port works only while operating
// - Latched fault holds partial shutdown until cleared
// - Clear by control bit or enable pulse
// - Controller pulses enable high-low-high within window
// - Too long a low pulse means full shutdown
// - Valid pulse clears faults, keeps all settings
// - Frames are 16 bits: command then data
// - Bit 15 direction, 14..11 address, rest data
// - Serial clock low at both select edges
// - Select high 400 ns between words
// - Select high: ignore pins, release output
// - Sample on falling, change on rising
// - Most significant bit first both ways
// - Not exactly 16 clocks: frame error, discard
// - Reply: five filler bits then register data
// - Write replies old value, read current value
// - Registers default on reset, sleep, undervoltage
// - Enable low past sleep delay: sleep
// - Report-only overcurrent latches flag, no shutdown
module gdc_device #(
    parameter int RST_CYC = gdc_pkg::RST_CYC,
    parameter int SLEEP_CYC = gdc_pkg::SLEEP_CYC,
    parameter int FLT_W = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    gdc_spi_if.dev spi,
    input wire logic motor_supply_ok,
    input wire logic [FLT_W-1:0] fault_cond,
    output logic operating_q,
    output logic partial_shutdown_q,
    output logic fault_out_n_q,
    output logic frame_error_q
);
    if (FLT_W < 1 || FLT_W > 9 || RST_CYC < 1 || SLEEP_CYC <= RST_CYC)
    begin : g_chk
        $error("gdc_device: parameter out of range");
    end

    localparam int DW = gdc_pkg::DATA_W;
    localparam int AW = gdc_pkg::ADDR_W;
    localparam int CW = gdc_pkg::CNT_W;

    typedef enum logic [2:0] {
        M_SLEEP = 3'b001,
        M_OPER = 3'b010,
        M_STBY = 3'b100
    } gdc_mode_t;

    gdc_mode_t mode_q;
    logic [4:0] s1_q, s2_q;
    logic sclk_d_q, cs_d_q;
    logic en, cs_n, sclk, sdi, uv_ok;
    logic sclk_rise, sclk_fall, cs_rise;
    logic [31:0] low_q;
    logic pulse_clr, spi_clr_q, clr_req;
    logic [FLT_W-1:0] flt_q, shut_mask;
    logic [DW-1:0] regs_q [gdc_pkg::ADDR_CFG_LO:gdc_pkg::ADDR_CFG_HI];
    logic [CW-1:0] cnt_q;
    logic [15:0] rx_q;
    logic [DW-1:0] tx_q;
    logic sdo_q, sdo_oe_q;
    logic [AW-1:0] rx_addr, cur_addr;
    logic good_frame;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers; third stage only feeds edge detection
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s1_q <= gdc_pkg::SYNC_RST;
            s2_q <= gdc_pkg::SYNC_RST;
            sclk_d_q <= 1'b0;
            cs_d_q <= 1'b1;
        end
        else
        begin
            s1_q <= {spi.enable, spi.chip_select_n, spi.sclk, spi.sdi,
                motor_supply_ok};
            s2_q <= s1_q;
            sclk_d_q <= s2_q[2];
            cs_d_q <= s2_q[3];
        end
    end

    assign {en, cs_n, sclk, sdi, uv_ok} = s2_q;
    assign sclk_rise = sclk & ~sclk_d_q;
    assign sclk_fall = ~sclk & sclk_d_q;
    assign cs_rise = cs_n & ~cs_d_q;

    ////////////////////////////////////////////////////////////////////
    // Mode control from enable and supply
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            mode_q <= M_SLEEP;
        else
        begin
            unique case (mode_q)
                M_SLEEP:
                    if (en && uv_ok)
                        mode_q <= M_OPER;
                M_OPER:
                    if (!uv_ok)
                        mode_q <= M_SLEEP;
                    else if (!en)
                        mode_q <= M_STBY;
                M_STBY:
                    if (!uv_ok)
                        mode_q <= M_SLEEP;
                    else if (en && low_q > 32'(RST_CYC))
                        mode_q <= M_SLEEP;
                    else if (en)
                        mode_q <= M_OPER;
                    else if (low_q == 32'(SLEEP_CYC - 1))
                        mode_q <= M_SLEEP;
            endcase
        end
    end

    // Length of the current enable low interval
    always_ff @(posedge sys_clk)
    begin
        if (rst || mode_q != M_STBY || en)
            low_q <= 32'h00000000;
        else
            low_q <= low_q + 32'h00000001;
    end

    // Short low pulse only clears faults, leaves all else alone
    assign pulse_clr = (mode_q == M_STBY) && en && uv_ok &&
        low_q <= 32'(RST_CYC);
    assign clr_req = pulse_clr | spi_clr_q;

    ////////////////////////////////////////////////////////////////////
    // Fault latches; a live condition wins over a clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            flt_q <= '0;
        else
            flt_q <= fault_cond | (flt_q & ~{FLT_W{clr_req}});
    end

    // Bit 0 is overcurrent; report-only mode keeps drivers running
    always_comb
    begin
        shut_mask = '1;
        shut_mask[0] = regs_q[gdc_pkg::ADDR_OCP][gdc_pkg::OCP_LSB+1 -:
            2] != gdc_pkg::OCP_REPORT;
    end

    // Status outputs
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            partial_shutdown_q <= 1'b0;
            fault_out_n_q <= 1'b1;
            operating_q <= 1'b0;
        end
        else
        begin
            partial_shutdown_q <= |(flt_q & shut_mask);
            fault_out_n_q <= ~|flt_q;
            operating_q <= (mode_q == M_OPER);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read view
    function automatic logic [DW-1:0] rd_reg(input logic [AW-1:0] a);
        logic [DW-1:0] v;
        v = '0;
        if (a == gdc_pkg::ADDR_STAT)
            v = {|flt_q, (DW-1-FLT_W)'(0), flt_q};
        else if (a >= gdc_pkg::ADDR_CFG_LO && a <= gdc_pkg::ADDR_CFG_HI)
            v = regs_q[a];
        return v;
    endfunction

    assign rx_addr = rx_q[14:11];
    assign cur_addr = {rx_q[2:0], sdi};
    assign good_frame = cs_rise && cnt_q == gdc_pkg::CNT_FULL &&
        mode_q == M_OPER;

    // Shift engine, active only while operating and selected
    always_ff @(posedge sys_clk)
    begin
        if (rst || cs_n || mode_q != M_OPER)
        begin
            cnt_q <= '0;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            if (rst)
            begin
                rx_q <= 16'h0000;
                tx_q <= '0;
            end
        end
        else
        begin
            sdo_oe_q <= 1'b1;
            if (sclk_fall)
            begin
                rx_q <= {rx_q[14:0], sdi};
                if (cnt_q != gdc_pkg::CNT_OVER)
                    cnt_q <= cnt_q + CW'(1);
                if (cnt_q == CW'(gdc_pkg::CMD_BITS - 1))
                    tx_q <= rd_reg(cur_addr);
            end
            if (sclk_rise && cnt_q >= CW'(gdc_pkg::CMD_BITS))
            begin
                sdo_q <= tx_q[DW-1];
                tx_q <= {tx_q[DW-2:0], 1'b0};
            end
        end
    end

    assign spi.sdo_o = sdo_q;
    assign spi.sdo_oe = sdo_oe_q;

    ////////////////////////////////////////////////////////////////////
    // Commit on select release; defaults whenever asleep
    always_ff @(posedge sys_clk)
    begin
        if (rst || mode_q == M_SLEEP)
        begin
            for (int i = gdc_pkg::ADDR_CFG_LO; i <= gdc_pkg::ADDR_CFG_HI;
                i++)
                regs_q[i] <= gdc_pkg::REG_DEFAULT;
            spi_clr_q <= 1'b0;
        end
        else
        begin
            spi_clr_q <= 1'b0;
            if (good_frame && !rx_q[15] &&
                rx_addr >= gdc_pkg::ADDR_CFG_LO &&
                rx_addr <= gdc_pkg::ADDR_CFG_HI)
            begin
                regs_q[rx_addr] <= rx_q[DW-1:0];
                if (rx_addr == gdc_pkg::ADDR_CTRL)
                begin
                    regs_q[rx_addr][gdc_pkg::CLR_BIT] <= 1'b0;
                    spi_clr_q <= rx_q[gdc_pkg::CLR_BIT];
                end
            end
        end
    end

    // One-cycle error strobe for short or long frames
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            frame_error_q <= 1'b0;
        else
            frame_error_q <= cs_rise && mode_q == M_OPER &&
                cnt_q != gdc_pkg::CNT_FULL;
    end
endmodule // gdc_device

// File: verification/gdc_checker.sv
// Concurrent checks on the serial link between host and device
`timescale 1ns/1ps
module gdc_checker #(
    parameter int GAP = gdc_pkg::GAP_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic chip_select_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic sdo
);
    logic [7:0] gap_q;
    logic [4:0] rise_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Select-high time; saturates so long idles never wrap
    always_ff @(posedge sys_clk)
    begin
        if (rst || !chip_select_n)
            gap_q <= 8'h00;
        else if (gap_q != 8'hFF)
            gap_q <= gap_q + 8'h01;
    end
    // Clock rises seen in the current frame
    always_ff @(posedge sys_clk)
    begin
        if (rst || chip_select_n)
            rise_q <= 5'h00;
        else if ($rose(sclk))
            rise_q <= rise_q + 5'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    a_sclk_low_fall: assert property ($fell(chip_select_n) |-> !sclk)
        else $error("sclk high at select fall");
    a_sclk_low_rise: assert property ($rose(chip_select_n) |-> !sclk)
        else $error("sclk high at select rise");
    a_select_gap: assert property (
        $fell(chip_select_n) |-> gap_q >= GAP)
        else $error("select gap too short");
    a_sixteen_clocks: assert property (
        $rose(chip_select_n) |-> rise_q == 5'h10)
        else $error("frame without 16 clocks");
    a_sdi_on_rise: assert property (
        !chip_select_n && $changed(sdi) |-> $rose(sclk))
        else $error("sdi moved off a rising clock");
    a_sdo_steady: assert property (
        $fell(sclk) && !chip_select_n |=> $stable(sdo_o)[*3])
        else $error("sdo moved near sampling");
    a_sdo_release: assert property (chip_select_n [*6] |-> !sdo_oe)
        else $error("sdo driven while deselected");
    a_filler_zero: assert property (
        $rose(sclk) && rise_q != 5'h00 && rise_q <= 5'h05 |-> !sdo)
        else $error("reply filler bit not zero");
    // Main traffic seen at least once
    cover property ($rose(chip_select_n));
    cover property ($rose(sdo_oe));
    cover property ($rose(sdo) && !chip_select_n);
endmodule // gdc_checker

// File: verification/gate_driver_spi_control_test.sv
// Bench joining host and device, plus a bit-banged second device
`timescale 1ns/1ps
module gate_driver_spi_control_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic [2:0] hsize = 3'h2;
    logic supply_ok = 1'b1;
    logic [3:0] flt = 4'h0;
    logic op, psd, fon, fer, fer2;
    logic ferr_seen = 1'b0;
    logic host_ferr = 1'b0;
    logic [31:0] rd;
    int errors = 0;
    int check_count = 0;
    // Frame sent, reply expected
    logic [15:0] rows [10][2] = '{'{16'h1955, 16'h0}, '{16'h9800, 16'h155},
        '{16'h1AAA, 16'h155}, '{16'h3FFF, 16'h0}, '{16'hB800, 16'h7FF},
        '{16'h3400, 16'h0}, '{16'hB000, 16'h400}, '{16'h0923, 16'h0},
        '{16'h8800, 16'h0}, '{16'h9800, 16'h2AA}};
    gdc_spi_if spi ();
    gdc_spi_if spi2 ();
    gdc_host #(.WAKE(60), .PULSE(10)) gdc_host_i (.sys_clk(sys_clk),
        .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .spi(spi.host));
    gdc_device #(.RST_CYC(20), .SLEEP_CYC(50)) gdc_device_i (
        .sys_clk(sys_clk), .rst(rst), .spi(spi.dev),
        .motor_supply_ok(supply_ok), .fault_cond(flt), .operating_q(op),
        .partial_shutdown_q(psd), .fault_out_n_q(fon), .frame_error_q(fer));
    gdc_device gdc_device_i2 (
        .sys_clk(sys_clk), .rst(rst), .spi(spi2.dev),
        .motor_supply_ok(supply_ok), .fault_cond(flt), .operating_q(),
        .partial_shutdown_q(), .fault_out_n_q(), .frame_error_q(fer2));
    gdc_checker gdc_checker_i (.sys_clk(sys_clk), .rst(rst),
        .chip_select_n(spi.chip_select_n), .sclk(spi.sclk), .sdi(spi.sdi),
        .sdo_o(spi.sdo_o), .sdo_oe(spi.sdo_oe), .sdo(spi.sdo));
    ////////////////////////////////////////////////////////////////////////
    always #5 sys_clk = ~sys_clk;
    // Error pulse is one cycle wide, so keep it
    always @(posedge sys_clk)
        if (fer2 === 1'b1)
            ferr_seen <= 1'b1;
    // Host traffic must never raise a frame error
    always @(posedge sys_clk)
        if (!rst && fer !== 1'b0)
            host_ferr <= 1'b1;
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Bounded wait for hready seen high at an edge
    task automatic wait_rdy();
        for (int i = 0; i < 50; i++)
        begin
            @(posedge sys_clk);
            if (hready === 1'b1)
                return;
        end
        check(hready, 1'b1);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic poll(input int b, input logic v);
        for (int i = 0; i < 400; i++)
        begin
            ahb(1'b0, gdc_pkg::H_STAT, 32'h0);
            if (rd[b] === v)
                return;
        end
        check(rd[b], v);
    endtask
    // One whole frame through the host, reply left in rd
    task automatic frame(input logic [15:0] tx);
        ahb(1'b1, gdc_pkg::H_TX, {16'h0, tx});
        ahb(1'b1, gdc_pkg::H_CTRL, 32'h3);
        poll(gdc_pkg::HS_BUSY, 1'b0);
        ahb(1'b0, gdc_pkg::H_RX, 32'h0);
    endtask
    task automatic pulse_flt();
        flt <= 4'h1;
        cyc(5);
        flt <= 4'h0;
        cyc(5);
    endtask
    // Sample at end of each low half; data never parks at last value
    task automatic bang(input int n, input logic [15:0] w);
        rd = 32'h0;
        spi2.chip_select_n <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            cyc(4);
            rd = {rd[30:0], spi2.sdo};
            spi2.sclk <= 1'b1;
            spi2.sdi <= (i < 16) ? w[15 - i] : 1'b0;
            cyc(4);
            spi2.sclk <= 1'b0;
        end
        cyc(4);
        rd = {rd[30:0], spi2.sdo};
        spi2.chip_select_n <= 1'b1;
        spi2.sdi <= ~spi2.sdi;
        cyc(45);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        spi2.enable <= 1'b0;
        spi2.chip_select_n <= 1'b1;
        spi2.sclk <= 1'b0;
        spi2.sdi <= 1'b0;
        cyc(4);
        rst <= 1'b0;
        cyc(1);
        check({hready, hresp, spi.chip_select_n, op, fon}, 5'h15);
        ahb(1'b0, gdc_pkg::H_CTRL, 32'h0);
        check(rd, 32'h0);
        ahb(1'b1, gdc_pkg::H_CTRL, 32'h1);
        poll(gdc_pkg::HS_READY, 1'b1);
        check(op, 1'b1);
        foreach (rows[i])
        begin
            frame(rows[i][0]);
            check(rd, {16'h0, rows[i][1]});
        end
        pulse_flt();
        check({psd, fon}, 2'b10);
        flt <= 4'h1;
        frame(16'h1001);
        check(psd, 1'b1);
        flt <= 4'h0;
        frame(16'h1001);
        check({psd, fon}, 2'b01);
        frame(16'h9000);
        check(rd, 32'h0);
        frame(16'h20AB);
        pulse_flt();
        ahb(1'b1, gdc_pkg::H_CTRL, 32'h5);
        poll(gdc_pkg::HS_BUSY, 1'b0);
        cyc(5);
        check({psd, fon}, 2'b01);
        frame(16'hA000);
        check(rd, 32'hAB);
        frame(16'h2880);
        pulse_flt();
        check({psd, fon}, 2'b00);
        frame(16'h1001);
        check(fon, 1'b1);
        ahb(1'b1, gdc_pkg::H_CTRL, 32'h0);
        cyc(10);
        check(op, 1'b0);
        cyc(15);
        ahb(1'b1, gdc_pkg::H_CTRL, 32'h1);
        poll(gdc_pkg::HS_READY, 1'b1);
        frame(16'hA000);
        check(rd, 32'h0);
        frame(16'h20AB);
        ahb(1'b1, gdc_pkg::H_CTRL, 32'h0);
        cyc(60);
        ahb(1'b1, gdc_pkg::H_CTRL, 32'h1);
        poll(gdc_pkg::HS_READY, 1'b1);
        frame(16'hA000);
        check(rd, 32'h0);
        frame(16'h1955);
        supply_ok <= 1'b0;
        cyc(10);
        check(op, 1'b0);
        supply_ok <= 1'b1;
        cyc(60);
        frame(16'h9800);
        check(rd, 32'h0);
        spi2.enable <= 1'b1;
        cyc(30);
        bang(16, 16'h1955);
        bang(16, 16'h9800);
        check({ferr_seen, rd[15:0]}, 17'h155);
        bang(15, 16'h1AAA);
        check(ferr_seen, 1'b1);
        ferr_seen = 1'b0;
        bang(17, 16'h1AAA);
        check(ferr_seen, 1'b1);
        ferr_seen = 1'b0;
        bang(16, 16'h9800);
        check({ferr_seen, rd[15:0]}, 17'h155);
        check(host_ferr, 1'b0);
        print_verdict();
    end
    // Run takes well under this span
    initial
    begin
        #500000;
        errors++;
        print_verdict();
    end
endmodule // gate_driver_spi_control_test
